// *** design/pot_cfg.svh ***
`ifndef POT_CFG_SVH
`define POT_CFG_SVH

// command opcodes carried in the low two bits of the command field
`define OP_WRITE      2'h0
`define OP_INC        2'h1
`define OP_DEC        2'h2
`define OP_READ       2'h3

// address map of the serial command space
`define ADDR_VW0      4'h0
`define ADDR_VW1      4'h1
`define ADDR_NW0      4'h2
`define ADDR_NW1      4'h3
`define ADDR_TC0      4'h4
`define ADDR_VW2      4'h6
`define ADDR_VW3      4'h7
`define ADDR_NW2      4'h8
`define ADDR_NW3      4'h9
`define ADDR_TC1      4'hA

// address kinds
`define KIND_VOL      2'h0
`define KIND_NV       2'h1
`define KIND_TERMINAL_CONTROL_REG     2'h2
`define KIND_NONE     2'h3

// terminal control nibble fields and reset value
`define TC_HW         3
`define TC_A          2
`define TC_W          1
`define TC_B          0
`define TC_RESET      4'hF

// default non-volatile wiper after an erase (mid scale of 8-bit part)
`define NV_WIPER_RST  10'h080
`define VW_RST        10'h000

// bit counts inside a frame, and the recall step count
`define DECODE_POS    5'h06
`define CMD_BITS      5'h08
`define FRAME_BITS    5'h10
`define RECALL_DONE   3'h4

`endif

// *** design/pot_pkg.sv ***
package pot_pkg;
    typedef logic [9:0] wiper_t;
    typedef logic [3:0] terminal_control_reg_nib_t;
    typedef enum logic [1:0] {ST_RECALL, ST_IDLE, ST_ACTIVE, ST_FAULT} fsm_t;
endpackage

// *** design/nv_mem_if.sv ***
`timescale 1ns/10ps
interface nv_mem_if;
    logic              wr_en;
    logic [1:0]        wr_addr;
    pot_pkg::wiper_t   wr_data;
    logic [1:0]        rd_addr;
    pot_pkg::wiper_t   rd_data;
    logic              lock_set;
    logic              lock_clr;
    logic [1:0]        lock_idx;
    logic [3:0]        lock;
    logic              erase;
    modport ctrl (output wr_en, wr_addr, wr_data, rd_addr, lock_set, lock_clr, lock_idx,
                  erase, input rd_data, lock);
    modport mem  (input wr_en, wr_addr, wr_data, rd_addr, lock_set, lock_clr, lock_idx,
                  erase, output rd_data, lock);
endinterface

// *** design/bit_sync.sv ***
`timescale 1ns/10ps
module bit_sync #(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    // ==========================================
    // two-stage synchroniser per bit
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic meta_q;
            // first stage feeds only the second stage
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    meta_q  <= RST_VAL[i];
                    dout[i] <= RST_VAL[i];
                end else if (clk_en) begin
                    meta_q  <= din[i];
                    dout[i] <= meta_q;
                end
            end
        end
    endgenerate
endmodule // bit_sync

// *** design/nv_store.sv ***
`timescale 1ns/10ps
`include "pot_cfg.svh"
module nv_store (
    input  wire logic clock,
    input  wire logic clk_en,
    nv_mem_if.mem     mif
);
    import pot_pkg::*;

    // ==========================================
    // non-volatile wipers and lock bits
    // no reset on purpose: contents outlive reset like a real eeprom
    wiper_t     mem_q [4];
    logic [3:0] lock_q;

    // word storage with synchronous erase to defaults
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (mif.erase) begin
                for (int k = 0; k < 4; k++) begin
                    mem_q[k] <= `NV_WIPER_RST;
                end
            end else if (mif.wr_en) begin
                mem_q[mif.wr_addr] <= mif.wr_data;
            end
        end
    end

    // lock bits, changed only by the controller's high-voltage path or cleared by erase
    always_ff @(posedge clock) begin
        if (clk_en) begin
            if (mif.erase) begin
                lock_q <= 4'h0;
            end else if (mif.lock_set) begin
                lock_q[mif.lock_idx] <= 1'b1;
            end else if (mif.lock_clr) begin
                lock_q[mif.lock_idx] <= 1'b0;
            end
        end
    end

    // registered read port
    always_ff @(posedge clock) begin
        if (clk_en) begin
            mif.rd_data <= mem_q[mif.rd_addr];
        end
    end

    assign mif.lock = lock_q;
endmodule // nv_store

// *** design/quad_pot_wiper_terminal_ctrl.sv ***
// Function
// - above full scale acts full, steps ignored
// - four lock bits, one per network
// - locked network ignores wiper and terminal writes
// - lock changes only by high-voltage command or erase
// - lock state survives reset untouched
// - reset reloads volatile wipers from non-volatile
// - terminal register connects A, B, wiper
// - force low: A open, wiper to B
// - forced shutdown overrides but keeps connect bits
// - shutdown never alters wipers; release restores position
// - slave only, host supplies serial clock
// - mode from clock level at select start
// - eight or sixteen bits framed by select
// - input bit captured on clock rise
// - output bit changes on clock fall
// - output driven while selected, content per position
// - select release resets interface, ignores activity
// - address field and opcode decode, steps volatile only
// - six high bits, then error bit seventh
// - error drives low, held until release
`timescale 1ns/10ps
`include "pot_cfg.svh"
module quad_pot_wiper_terminal_ctrl #(
    parameter int WIPER_BITS = 8
) (
    input  wire logic                 clock,
    input  wire logic                 reset_n,
    input  wire logic                 clk_en,
    input  wire logic                 spi_sck,
    input  wire logic                 spi_sdi,
    input  wire logic                 spi_cs_n,
    input  wire logic                 high_voltage_level,
    input  wire logic                 nv_erase,
    output logic                      spi_sdo,
    output logic                      spi_sdo_oe,
    output pot_pkg::wiper_t [3:0]     wiper_code,
    output pot_pkg::wiper_t [3:0]     wiper_tap,
    output logic [3:0]                term_a_connect,
    output logic [3:0]                term_w_connect,
    output logic [3:0]                term_b_connect,
    output logic [3:0]                wiper_b_short,
    output pot_pkg::terminal_control_reg_nib_t [3:0]  terminal_control_reg,
    output logic [3:0]                network_lock_bit,
    output logic                      command_error_flag,
    output logic                      recall_busy,
    output logic                      spi_mode_11
);
    import pot_pkg::*;

    localparam wiper_t FULL_SCALE = wiper_t'(1 << WIPER_BITS);

    // ==========================================
    // decode helpers
    function automatic logic [1:0] addr_kind(input logic [3:0] a);
        case (a)
            `ADDR_VW0, `ADDR_VW1, `ADDR_VW2, `ADDR_VW3: addr_kind = `KIND_VOL;
            `ADDR_NW0, `ADDR_NW1, `ADDR_NW2, `ADDR_NW3: addr_kind = `KIND_NV;
            `ADDR_TC0, `ADDR_TC1:                       addr_kind = `KIND_TERMINAL_CONTROL_REG;
            default:                                    addr_kind = `KIND_NONE;
        endcase
    endfunction

    // network index; a terminal register reports its lower network
    function automatic logic [1:0] addr_net(input logic [3:0] a);
        case (a)
            `ADDR_VW0, `ADDR_NW0, `ADDR_TC0: addr_net = 2'h0;
            `ADDR_VW1, `ADDR_NW1:            addr_net = 2'h1;
            `ADDR_VW2, `ADDR_NW2, `ADDR_TC1: addr_net = 2'h2;
            default:                         addr_net = 2'h3;
        endcase
    endfunction

    // legal command: steps on volatile, or high-voltage on non-volatile
    function automatic logic cmd_ok(input logic [3:0] a, input logic [1:0] op,
                                    input logic hv);
        logic [1:0] k;
        k = addr_kind(a);
        if (k == `KIND_NONE) begin
            cmd_ok = 1'b0;
        end else if (op == `OP_INC || op == `OP_DEC) begin
            cmd_ok = (k == `KIND_VOL) || (k == `KIND_NV && hv);
        end else begin
            cmd_ok = 1'b1;
        end
    endfunction

    // saturating step; codes above full scale never move
    function automatic wiper_t step_wiper(input wiper_t w, input logic up);
        if (w > FULL_SCALE) begin
            step_wiper = w;
        end else if (up && w < FULL_SCALE) begin
            step_wiper = w + 10'h001;
        end else if (!up && w != 10'h000) begin
            step_wiper = w - 10'h001;
        end else begin
            step_wiper = w;
        end
    endfunction

    // ==========================================
    // pin synchronisers and edge finding
    // the serial clock is sampled, not used as a clock: slave only
    logic       cs_n_s, sck_s, sdi_s, hv_s;
    logic       sck_prev_q, cs_prev_q;
    logic       sck_rise, sck_fall, cs_start;

    bit_sync #(
        .W       (4),
        .RST_VAL (4'h8)
    ) u_sync (
        .clock   (clock),
        .reset_n (reset_n),
        .clk_en  (clk_en),
        .din     ({spi_cs_n, spi_sck, spi_sdi, high_voltage_level}),
        .dout    ({cs_n_s, sck_s, sdi_s, hv_s})
    );

    // previous levels for edge detection
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
        end else if (clk_en) begin
            sck_prev_q <= sck_s;
            cs_prev_q  <= cs_n_s;
        end
    end

    assign sck_rise = sck_s & ~sck_prev_q;
    assign sck_fall = ~sck_s & sck_prev_q;
    assign cs_start = cs_prev_q & ~cs_n_s;

    // ==========================================
    // non-volatile store
    nv_mem_if mif ();

    nv_store u_nv (
        .clock  (clock),
        .clk_en (clk_en),
        .mif    (mif)
    );

    // ==========================================
    // frame state
    fsm_t          state_q;
    logic [2:0]    recall_cnt_q;
    logic [4:0]    bit_cnt_q;
    logic [15:0]   shift_q;
    logic [5:0]    cmd_q;
    logic          hv_q;
    logic          mode_q;
    logic [1:0]    rd_pipe_q;
    wiper_t        rd_val_q;
    logic          sdo_q;
    wiper_t        vw_q [4];
    terminal_control_reg_nib_t     terminal_control_reg_q [4];

    logic          frame_rise, at_decode, err_now, at_end8, at_end16;
    logic          wr_fire, step_fire, recall_ld;
    logic [4:0]    bits_next;
    logic [15:0]   shift_next;
    logic [3:0]    cur_addr, cmd_addr;
    logic [1:0]    cur_op, cmd_op, cmd_kind, cmd_net, recall_idx;
    wiper_t        wr_data;

    assign frame_rise = (state_q == ST_ACTIVE) && sck_rise;
    assign bits_next  = bit_cnt_q + 5'h01;
    assign shift_next = {shift_q[14:0], sdi_s};
    assign cur_addr   = shift_next[5:2];
    assign cur_op     = shift_next[1:0];
    assign cmd_addr   = cmd_q[5:2];
    assign cmd_op     = cmd_q[1:0];
    assign cmd_kind   = addr_kind(cmd_addr);
    assign cmd_net    = addr_net(cmd_addr);
    assign at_decode  = frame_rise && (bits_next == `DECODE_POS);
    assign err_now    = at_decode && !cmd_ok(cur_addr, cur_op, hv_q);
    // steps end after the command byte, reads and writes after two bytes
    assign at_end8    = frame_rise && (bits_next == `CMD_BITS) &&
                        (cmd_op == `OP_INC || cmd_op == `OP_DEC);
    assign at_end16   = frame_rise && (bits_next == `FRAME_BITS) &&
                        (cmd_op == `OP_READ || cmd_op == `OP_WRITE);
    assign wr_fire    = at_end16 && (cmd_op == `OP_WRITE);
    assign step_fire  = at_end8;
    assign wr_data    = shift_next[9:0];
    assign recall_ld  = (state_q == ST_RECALL) && (recall_cnt_q != 3'h0);
    assign recall_idx = 2'(recall_cnt_q - 3'h1);

    // main sequencer
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_RECALL;
        end else if (clk_en) begin
            case (state_q)
                ST_RECALL: begin
                    if (recall_cnt_q == `RECALL_DONE) begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_IDLE: begin
                    if (cs_start) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (cs_n_s) begin
                        state_q <= ST_IDLE;
                    end else if (err_now) begin
                        state_q <= ST_FAULT;
                    end
                end
                ST_FAULT: begin
                    if (cs_n_s) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // recall counter walks the four stored wipers after reset
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            recall_cnt_q <= 3'h0;
        end else if (clk_en && state_q == ST_RECALL && recall_cnt_q != `RECALL_DONE) begin
            recall_cnt_q <= recall_cnt_q + 3'h1;
        end
    end

    // frame-start capture of clock mode and select voltage level
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            mode_q <= 1'b0;
            hv_q   <= 1'b0;
        end else if (clk_en && state_q == ST_IDLE && cs_start) begin
            mode_q <= sck_s;
            hv_q   <= hv_s;
        end
    end

    // bit counter and shifter; back-to-back commands restart at zero
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bit_cnt_q <= 5'h00;
            shift_q   <= 16'h0000;
        end else if (clk_en) begin
            if (state_q != ST_ACTIVE || cs_n_s) begin
                bit_cnt_q <= 5'h00;
                shift_q   <= 16'h0000;
            end else if (frame_rise) begin
                shift_q   <= shift_next;
                bit_cnt_q <= (at_end8 || at_end16) ? 5'h00 : bits_next;
            end
        end
    end

    // command field latched once address and opcode are in
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cmd_q <= 6'h00;
        end else if (clk_en && at_decode) begin
            cmd_q <= shift_next[5:0];
        end
    end

    // read data capture; the store answers two cycles after decode
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_pipe_q <= 2'h0;
            rd_val_q  <= 10'h000;
        end else if (clk_en) begin
            rd_pipe_q <= {rd_pipe_q[0],
                          at_decode && cur_op == `OP_READ && addr_kind(cur_addr) == `KIND_NV};
            if (at_decode && cur_op == `OP_READ) begin
                case (addr_kind(cur_addr))
                    `KIND_VOL:  rd_val_q <= vw_q[addr_net(cur_addr)];
                    `KIND_TERMINAL_CONTROL_REG: rd_val_q <= {2'b01, terminal_control_reg_q[addr_net(cur_addr) | 2'h1],
                                             terminal_control_reg_q[addr_net(cur_addr)]};
                    default:    rd_val_q <= 10'h000;
                endcase
            end else if (rd_pipe_q[1]) begin
                rd_val_q <= mif.rd_data;
            end
        end
    end

    // serial output, moved on falling clock edges, set high at frame start and low in fault
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sdo_q <= 1'b1;
        end else if (clk_en) begin
            if (state_q == ST_IDLE && cs_start) begin
                sdo_q <= 1'b1;
            end else if (state_q == ST_FAULT) begin
                sdo_q <= 1'b0;
            end else if (state_q == ST_ACTIVE && sck_fall) begin
                if (bit_cnt_q < `DECODE_POS) begin
                    sdo_q <= 1'b1;
                end else if (bit_cnt_q == `DECODE_POS) begin
                    sdo_q <= 1'b1;
                end else if (cmd_op == `OP_READ) begin
                    sdo_q <= rd_val_q[4'(5'h0F - bit_cnt_q)];
                end else begin
                    sdo_q <= 1'b1;
                end
            end
        end
    end

    // driven whenever select is low once recall is over
    assign spi_sdo_oe = ~cs_n_s && (state_q != ST_RECALL);
    assign spi_sdo    = sdo_q;

    // ==========================================
    // store access: writes and lock changes
    assign mif.rd_addr  = (state_q == ST_RECALL) ? recall_cnt_q[1:0] : cmd_net;
    assign mif.wr_en    = wr_fire && cmd_kind == `KIND_NV && !mif.lock[cmd_net];
    assign mif.wr_addr  = cmd_net;
    assign mif.wr_data  = wr_data;
    // high-voltage step on a stored wiper address: decrement locks
    assign mif.lock_set = step_fire && hv_q && cmd_kind == `KIND_NV &&
                          cmd_op == `OP_DEC;
    assign mif.lock_clr = step_fire && hv_q && cmd_kind == `KIND_NV &&
                          cmd_op == `OP_INC;
    assign mif.lock_idx = cmd_net;
    assign mif.erase    = nv_erase;

    // ==========================================
    // per-network wiper and terminal state
    genvar n;
    generate
        for (n = 0; n < 4; n++) begin : g_net
            localparam logic [1:0] NI = 2'(n);
            logic hit, tc_hit, locked, hw;

            assign locked = mif.lock[NI];
            assign hit    = (cmd_net == NI) && (cmd_kind == `KIND_VOL);
            assign tc_hit = (cmd_kind == `KIND_TERMINAL_CONTROL_REG) && (cmd_net == (NI & 2'h2));
            assign hw     = terminal_control_reg_q[n][`TC_HW];

            // volatile wiper: recall, write or step; shutdown never touches it
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    vw_q[n] <= `VW_RST;
                end else if (clk_en) begin
                    if (recall_ld && recall_idx == NI) begin
                        vw_q[n] <= mif.rd_data;
                    end else if (hit && !locked && wr_fire) begin
                        vw_q[n] <= wr_data;
                    end else if (hit && !locked && step_fire) begin
                        vw_q[n] <= step_wiper(vw_q[n], cmd_op == `OP_INC);
                    end
                end
            end

            // terminal control nibble; locked networks keep their bits
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    terminal_control_reg_q[n] <= `TC_RESET;
                end else if (clk_en && tc_hit && wr_fire && !locked) begin
                    terminal_control_reg_q[n] <= NI[0] ? wr_data[7:4] : wr_data[3:0];
                end
            end

            // terminal switches; forcing overrides without clearing bits
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    term_a_connect[n] <= 1'b1;
                    term_w_connect[n] <= 1'b1;
                    term_b_connect[n] <= 1'b1;
                    wiper_b_short[n]  <= 1'b0;
                end else if (clk_en) begin
                    term_a_connect[n] <= hw & terminal_control_reg_q[n][`TC_A];
                    term_w_connect[n] <= ~hw | terminal_control_reg_q[n][`TC_W];
                    term_b_connect[n] <= ~hw | terminal_control_reg_q[n][`TC_B];
                    wiper_b_short[n]  <= ~hw;
                end
            end

            // tap position: anything above full scale sits at full scale
            always_ff @(posedge clock or negedge reset_n) begin
                if (!reset_n) begin
                    wiper_tap[n] <= `VW_RST;
                end else if (clk_en) begin
                    wiper_tap[n] <= (vw_q[n] > FULL_SCALE) ? FULL_SCALE : vw_q[n];
                end
            end

            assign wiper_code[n]           = vw_q[n];
            assign terminal_control_reg[n] = terminal_control_reg_q[n];
        end
    endgenerate

    // ==========================================
    // status
    // lock bits come straight from the store, which reset leaves alone
    assign network_lock_bit   = mif.lock;
    assign command_error_flag = (state_q == ST_FAULT);
    assign recall_busy        = (state_q == ST_RECALL);
    assign spi_mode_11        = mode_q;
endmodule // quad_pot_wiper_terminal_ctrl

// *** sim/pot_ctrl_asserts.sv ***
`timescale 1ns/10ps
// ====================
// pin checks on the controller
module pot_ctrl_asserts (
    input wire logic       clock,
    input wire logic       reset_n,
    input wire logic       spi_sck,
    input wire logic       spi_cs_n,
    input wire logic       nv_erase,
    input wire logic       spi_sdo,
    input wire logic       spi_sdo_oe,
    input wire logic [3:0] term_a_connect,
    input wire logic [3:0] wiper_b_short,
    input wire logic [3:0] network_lock_bit,
    input wire logic       command_error_flag,
    input wire logic       recall_busy,
    input wire logic       spi_mode_11
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    // frame start as the host sees it, once recall is over
    sequence start_s;
        $fell(spi_cs_n) && !recall_busy;
    endsequence
    // select and error handling
    oe_off_a: assert property (spi_cs_n [*4] |-> !spi_sdo_oe && !command_error_flag)
        else $error("output or error left after deselect");
    oe_on_a: assert property ((!spi_cs_n && !recall_busy) [*4] |-> spi_sdo_oe)
        else $error("output not driven while selected");
    sdo_start_a: assert property (start_s |-> ##[3:6] spi_sdo_oe && spi_sdo)
        else $error("output not high at frame start");
    err_hold_a: assert property (command_error_flag && !spi_cs_n |=> command_error_flag)
        else $error("error dropped while selected");
    // the error bit shows one clock after the flag rises; the check allows up to 16 clocks
    err_sdo_a: assert property ($rose(command_error_flag) |-> ##[1:16] !spi_sdo)
        else $error("error bit not low");
    // two cycles of short allow one register of skew between the outputs
    shut_open_a: assert property (wiper_b_short[0] [*2] |-> !term_a_connect[0])
        else $error("terminal a connected in shutdown");
    lock_idle_a: assert property ((spi_cs_n && !nv_erase) [*4] |=> $stable(network_lock_bit))
        else $error("lock moved with no frame");
    mode_pick_a: assert property (start_s |-> ##6 spi_mode_11 == $past(spi_sck, 6))
        else $error("wrong clock mode");
endmodule // pot_ctrl_asserts
bind quad_pot_wiper_terminal_ctrl pot_ctrl_asserts u_pot_ctrl_asserts (.*);

// *** sim/spi_host_model.sv ***
`timescale 1ns/10ps
// ====================
// serial host: sole source of the link clock
module spi_host_model (
    output logic      spi_sck,
    output logic      spi_sdi,
    output logic      spi_cs_n,
    output logic      high_voltage_level,
    input  wire logic spi_sdo
);
    // idle: deselected, clock parked
    initial begin
        spi_sck = 1'b0;
        spi_sdi = 1'b0;
        spi_cs_n = 1'b1;
        high_voltage_level = 1'b0;
    end
    // one frame msb first; clock stands at the mode level outside it
    task automatic frame(input logic m, input logic hv, input int n,
                         input logic [15:0] d, output logic [15:0] rx);
        rx = 16'hFFFF;
        #1; // step off the sampling clock edge
        spi_sck = m;
        high_voltage_level = hv;
        #48 spi_cs_n = 1'b0;
        #48;
        for (int i = 0; i < n; i++) begin
            spi_sck = 1'b0;
            spi_sdi = d[15-i];
            #24 spi_sck = 1'b1;
            rx[15-i] = spi_sdo;
            #24;
        end
        spi_sck = m;
        #24 spi_cs_n = 1'b1;
        spi_sdi = ~spi_sdi; // released line must not keep its value
        high_voltage_level = 1'b0;
    endtask
endmodule // spi_host_model

// *** sim/tb_quad_pot_wiper_terminal_ctrl.sv ***
`timescale 1ns/10ps
`include "pot_cfg.svh"
`define CHK(nm, e, s) begin n_compared++; if ((s) !== (e)) begin miscompares++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, e, s); end end
// ====================
// bench for the pot controller
module tb_quad_pot_wiper_terminal_ctrl;
    import pot_pkg::*;
    logic            clock, reset_n, nv_erase, command_error_flag, recall_busy, spi_mode_11;
    logic            spi_sck, spi_sdi, spi_cs_n, high_voltage_level, spi_sdo, spi_sdo_oe;
    logic [3:0]      term_a_connect, wiper_b_short, network_lock_bit;
    logic [3:0]      term_w_connect, term_b_connect;
    wiper_t [3:0]    wiper_code, wiper_tap;
    terminal_control_reg_nib_t [3:0] terminal_control_reg;
    logic [15:0]     rx;
    int              miscompares = 0;
    int              n_compared = 0;
    // clock enable held on; link pins come from the host model
    quad_pot_wiper_terminal_ctrl u_quad_pot_wiper_terminal_ctrl (
        .*, .clk_en(1'b1));
    spi_host_model u_spi_host_model (.*);
    // ====================
    // clock, guard and tasks
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // a hang still ends with a verdict
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // erase overlaps reset so that recall reads a defined store
    task automatic do_reset(input logic erase);
        @(posedge clock);
        reset_n <= 1'b0;
        nv_erase <= erase;
        repeat (6) @(posedge clock);
        nv_erase <= 1'b0;
        reset_n <= 1'b1;
        repeat (12) @(posedge clock);
    endtask
    // steps take 8 bits, reads and writes 16
    task automatic cmd(input logic m, input logic h, input logic [3:0] a, input logic [1:0] op,
                       input logic [9:0] d);
        u_spi_host_model.frame(m, h, (op[0] ^ op[1]) ? 8 : 16, {a, op, d}, rx);
        repeat (10) @(posedge clock);
    endtask
    // ====================
    // scenarios
    initial begin
        reset_n = 1'b0;
        nv_erase = 1'b0;
        do_reset(1'b1);
        for (int i = 0; i < 4; i++) `CHK("recall", `NV_WIPER_RST, wiper_code[i])
        `CHK("locks", 4'h0, network_lock_bit)
        cmd(0, 0, `ADDR_VW0, `OP_WRITE, 10'h123);
        `CHK("wr sdo", 16'hFFFF, rx)
        `CHK("tap", 10'h100, wiper_tap[0])
        cmd(0, 0, `ADDR_VW0, `OP_DEC, 10'h000);
        `CHK("over", 10'h123, wiper_code[0])
        // full scale in mode 1,1, step down, then read back
        cmd(1, 0, `ADDR_VW0, `OP_WRITE, 10'h100);
        cmd(1, 0, `ADDR_VW0, `OP_INC, 10'h000);
        `CHK("full", 10'h100, wiper_code[0])
        cmd(1, 0, `ADDR_VW0, `OP_DEC, 10'h000);
        cmd(1, 0, `ADDR_VW0, `OP_READ, 10'h000);
        `CHK("rd sdo", 16'hFEFF, rx)
        `CHK("mode", 1'b1, spi_mode_11)
        // forced shutdown keeps the wiper and the stored bits
        cmd(0, 0, `ADDR_TC0, `OP_WRITE, 10'h0F0);
        `CHK("short", 1'b1, wiper_b_short[0])
        `CHK("a open", 1'b0, term_a_connect[0])
        `CHK("wb on", 2'h3, {term_w_connect[0], term_b_connect[0]})
        `CHK("tc kept", 4'h0, terminal_control_reg[0])
        `CHK("w kept", 10'h0FF, wiper_code[0])
        cmd(0, 0, `ADDR_TC0, `OP_WRITE, 10'h0F8);
        `CHK("a bit", 1'b0, term_a_connect[0])
        `CHK("wb bit", 2'h0, {term_w_connect[0], term_b_connect[0]})
        `CHK("mode", 1'b0, spi_mode_11)
        cmd(0, 0, `ADDR_VW0, `OP_WRITE, 10'h000);
        cmd(0, 0, `ADDR_VW0, `OP_DEC, 10'h000);
        `CHK("zero", 10'h000, wiper_code[0])
        // unmapped address, store step at normal level
        cmd(0, 0, 4'h5, `OP_WRITE, 10'h3FF);
        `CHK("bad addr", 16'hFC00, rx)
        cmd(0, 0, `ADDR_NW0, `OP_INC, 10'h000);
        `CHK("nv step", 8'hFC, rx[15:8])
        `CHK("err end", 1'b0, command_error_flag)
        // lock network 0 by high voltage, then try to change it
        cmd(0, 1, `ADDR_NW0, `OP_DEC, 10'h000);
        `CHK("lock", 4'h1, network_lock_bit)
        cmd(0, 0, `ADDR_VW0, `OP_WRITE, 10'h055);
        cmd(0, 0, `ADDR_TC0, `OP_WRITE, 10'h000);
        `CHK("locked w", 10'h000, wiper_code[0])
        `CHK("locked tc", 4'h8, terminal_control_reg[0])
        `CHK("free tc", 4'h0, terminal_control_reg[1])
        do_reset(1'b0);
        `CHK("lock kept", 4'h1, network_lock_bit)
        `CHK("reload", `NV_WIPER_RST, wiper_code[0])
        cmd(0, 1, `ADDR_NW0, `OP_INC, 10'h000);
        `CHK("unlock", 4'h0, network_lock_bit)
        final_report();
    end
endmodule // tb_quad_pot_wiper_terminal_ctrl
